// >>> inc/csm_pkg.sv
// Purpose: Shared constants and carriers for the cyclic/step-direction front end
// Assumes: 10 MHz clock, one clock domain
// Notes:   Offsets of fields in the status word and mode codes live here
package csm_pkg;
  // Mode selection codes, 8-bit view
  localparam logic [7:0] MODE_CSV     = 8'h09;
  localparam logic [7:0] MODE_CST     = 8'h0a;
  localparam logic [7:0] MODE_STEPDIR = 8'hff;
  // Supported time index, -3 as 8-bit two's complement
  localparam logic [7:0] TIME_INDEX_MS = 8'hfd;
  // Status word bit positions
  localparam int STAT_SYNC_BIT   = 8;
  localparam int STAT_FOLLOW_BIT = 12;
  localparam int STAT_FERR_BIT   = 13;
  // Clock rate and base time
  localparam int CLK_HZ        = 10000000;
  localparam int BASE_TIME_US  = 1000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000000 * BASE_TIME_US;
  // Step scaling defaults
  localparam logic [15:0] STEP_NUM_RST  = 16'h0080;
  localparam logic [15:0] STEP_DEN_RST  = 16'h0001;
  localparam logic [15:0] FULL_STEP     = 16'h0200;
  localparam logic [15:0] HALF_STEP     = 16'h0100;
  localparam logic [3:0]  STEPS_PER_PP  = 4'h4;
  // Reset values
  localparam logic [15:0] PERIOD_RST    = 16'h0001;
  localparam logic [15:0] MS_CNT_RST    = 16'h0000;
  // Pulse subtype codes
  localparam logic SUB_CLK_DIR    = 1'b0;
  localparam logic SUB_SPLIT_PINS = 1'b1;

  // Cyclic setpoint bundle from the fieldbus side
  typedef struct packed {
    logic signed [31:0] targetVel;
    logic signed [31:0] velOffset;
    logic signed [15:0] targetTorque;
    logic signed [15:0] torqueOffset;
    logic        [15:0] maxTorque;
    logic        [15:0] maxCurrent;
  } setpt_s;

  // Mode state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CSV  = 4'b0010,
    ST_CST  = 4'b0100,
    ST_STEP = 4'b1000
  } mode_e;
endpackage

// >>> hdl/cyclic_step_modes.sv
// Purpose: Cyclic velocity/torque setpoint handling and step/direction input
// Assumes: Inputs synchronous to clk; pulse source meets rate limits
// Notes:   Demand position only moves at cycle boundaries
`timescale 1ns/1ns
// How it works
// - Mode code 9 selects cyclic velocity operation.
// - Mode code 10 selects cyclic torque operation.
// - Mode code 0xFF selects step/direction pulse operation.
// - Control word bits carry no meaning in cyclic modes.
// - Status bit 8 shows fieldbus sync in cyclic modes; 10, 13 reserved.
// - Status bit 12 set while the cyclic target is used.
// - Cycle time is period times 1 ms; only index -3 accepted.
// - Velocity demand is target plus velocity offset.
// - Torque clamped to lesser of max torque and max current.
// - Torque target taken relative to max torque.
// - Torque offset added, one unit meaning a tenth of a percent.
// - Each step pulse moves demand one step in direction sense.
// - Pulses summed per cycle, applied once per cycle.
// - Each pulse scaled by numerator over denominator, default 128/1.
// - Step mode overrides flexible pin setup for clock and direction.
// - Closed-loop step mode flags following error past window timeout.
// - Subtype 0 takes steps from clock, sense from direction.
// - Subtype 1 takes sense from which input carries pulses.
// - Brushless motors counted as four full steps per pole pair.
module cyclic_step_modes (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Mode and cycle configuration
  input  wire logic [7:0]          modeSel,
  input  wire logic [15:0]         interpPeriod,
  input  wire logic [7:0]          timeIndex,
  input  wire logic                fieldbusSync,
  input  wire logic                targetValid,
  input  wire logic [15:0]         controlWord,
  // Cyclic setpoints
  input  wire csm_pkg::setpt_s     setpt,
  // Step/direction pins and scaling
  input  wire logic                pulseSubtype,
  input  wire logic                clockwisePulseInput,
  input  wire logic                directionInput,
  input  wire logic                counterclockwisePulseInput,
  input  wire logic [15:0]         stepNum,
  input  wire logic [15:0]         stepDen,
  input  wire logic [7:0]          polePairs,
  // Closed-loop following error supervision
  input  wire logic                closedLoop,
  input  wire logic signed [31:0]  actualPos,
  input  wire logic [31:0]         ferrWindow,
  input  wire logic [15:0]         ferrTimeoutMs,
  // Flexible pin configuration from user
  input  wire logic [1:0]          userAltMask,
  // Outputs
  output logic [15:0]              statusWord,
  output logic signed [31:0]       velDemand,
  output logic signed [15:0]       torqueDemand,
  output logic signed [31:0]       demandPos,
  output logic                     cycleTick,
  output logic [1:0]               pinAltMask,
  output logic [15:0]              stepsPerRev,
  output logic                     timeIndexErr
);

  csm_pkg::mode_e     mode_ff;
  csm_pkg::mode_e     nxt_mode;
  logic [15:0]        msCnt_ff;
  logic [15:0]        perCnt_ff;
  logic               msTick;
  logic               clkPrev_ff;
  logic               counterclockwisePrev_ff;
  logic signed [31:0] accum_ff;
  logic signed [1:0]  stepDelta;
  logic [15:0]        ferrMs_ff;
  logic signed [31:0] posErr;
  logic               errOut;
  logic signed [31:0] trqSum;

  // Unsigned minimum, used for the torque limit
  function automatic logic [15:0] umin(input logic [15:0] a,
                                       input logic [15:0] b);
    umin = (a < b) ? a : b;
  endfunction

  // Symmetric clamp of a signed value to +/- lim
  function automatic logic signed [31:0] clampS(input logic signed [31:0] v,
                                                input logic [15:0] lim);
    logic signed [31:0] l;
    l = $signed({16'h0000, lim});
    if (v > l) clampS = l;
    else if (v < -l) clampS = -l;
    else clampS = v;
  endfunction

  // Mode decode; control word is never looked at here
  always_comb begin
    case (modeSel)
      csm_pkg::MODE_CSV:     nxt_mode = csm_pkg::ST_CSV;
      csm_pkg::MODE_CST:     nxt_mode = csm_pkg::ST_CST;
      csm_pkg::MODE_STEPDIR: nxt_mode = csm_pkg::ST_STEP;
      default:               nxt_mode = csm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) mode_ff <= csm_pkg::ST_IDLE;
    else mode_ff <= nxt_mode;
  end

  // Millisecond base enable
  assign msTick = (msCnt_ff == 16'(csm_pkg::CYC_PER_MS - 1));
  always_ff @(posedge clk) begin
    if (!rst_b) msCnt_ff <= csm_pkg::MS_CNT_RST;
    else if (msTick) msCnt_ff <= csm_pkg::MS_CNT_RST;
    else msCnt_ff <= msCnt_ff + 16'h0001;
  end

  // Cycle counter: period in ms; unsupported index stalls the cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      perCnt_ff <= csm_pkg::MS_CNT_RST;
      cycleTick <= 1'b0;
      timeIndexErr <= 1'b0;
    end else begin
      timeIndexErr <= (timeIndex != csm_pkg::TIME_INDEX_MS);
      cycleTick <= 1'b0;
      if (timeIndex == csm_pkg::TIME_INDEX_MS && msTick) begin
        if (perCnt_ff + 16'h0001 >= interpPeriod) begin
          perCnt_ff <= csm_pkg::MS_CNT_RST;
          cycleTick <= 1'b1;
        end else begin
          perCnt_ff <= perCnt_ff + 16'h0001;
        end
      end
    end
  end

  // Cyclic velocity; host refreshes target each cycle
  always_ff @(posedge clk) begin
    if (!rst_b) velDemand <= 32'h00000000;
    else if (mode_ff == csm_pkg::ST_CSV && targetValid)
      velDemand <= setpt.targetVel + setpt.velOffset;
    else if (mode_ff != csm_pkg::ST_CSV) velDemand <= 32'h00000000;
  end

  // Cyclic torque: target and offset both in per-mille of max torque
  assign trqSum = 32'(setpt.targetTorque)
                + 32'(setpt.torqueOffset);
  always_ff @(posedge clk) begin
    if (!rst_b) torqueDemand <= 16'h0000;
    else if (mode_ff == csm_pkg::ST_CST && targetValid)
      torqueDemand <= 16'(clampS(trqSum, umin(setpt.maxTorque,
                                              setpt.maxCurrent)));
    else if (mode_ff != csm_pkg::ST_CST) torqueDemand <= 16'h0000;
  end

  // Edge detection of step inputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clkPrev_ff <= 1'b0;
      counterclockwisePrev_ff <= 1'b0;
    end else begin
      clkPrev_ff <= clockwisePulseInput;
      counterclockwisePrev_ff <= counterclockwisePulseInput;
    end
  end

  // Step direction per subtype; both edges at once cancel in split pins
  always_comb begin
    stepDelta = 2'sd0;
    if (pulseSubtype == csm_pkg::SUB_CLK_DIR) begin
      if (clockwisePulseInput && !clkPrev_ff)
        stepDelta = directionInput ? -2'sd1 : 2'sd1;
    end else begin
      if (clockwisePulseInput && !clkPrev_ff)
        stepDelta = stepDelta + 2'sd1;
      if (counterclockwisePulseInput && !counterclockwisePrev_ff)
        stepDelta = stepDelta - 2'sd1;
    end
  end

  // Per-cycle accumulator; pulses on the tick cycle start the next sum
  always_ff @(posedge clk) begin
    if (!rst_b || mode_ff != csm_pkg::ST_STEP) accum_ff <= 32'h00000000;
    else if (cycleTick) accum_ff <= 32'(stepDelta);
    else accum_ff <= accum_ff + 32'(stepDelta);
  end

  // Demand position applied once per cycle, scaled by num/den
  always_ff @(posedge clk) begin
    if (!rst_b) demandPos <= 32'h00000000;
    else if (mode_ff == csm_pkg::ST_STEP && cycleTick && stepDen != 16'h0000)
      demandPos <= demandPos + 32'((accum_ff * $signed({16'h0000, stepNum}))
                                   / $signed({16'h0000, stepDen}));
  end

  // Brushless treated as stepper: 4 full steps per pole pair
  always_ff @(posedge clk) begin
    if (!rst_b) stepsPerRev <= 16'h0000;
    else stepsPerRev <= 16'(polePairs)
                        * 16'(csm_pkg::STEPS_PER_PP);
  end

  // Step mode forces clock and direction alternate functions on
  always_ff @(posedge clk) begin
    if (!rst_b) pinAltMask <= 2'b00;
    else if (mode_ff == csm_pkg::ST_STEP) pinAltMask <= 2'b11;
    else pinAltMask <= userAltMask;
  end

  // Following error timer in ms
  assign posErr = demandPos - actualPos;
  assign errOut = (posErr > $signed(ferrWindow)) ||
                  (posErr < -$signed(ferrWindow));
  always_ff @(posedge clk) begin
    if (!rst_b || !errOut || mode_ff != csm_pkg::ST_STEP)
      ferrMs_ff <= 16'h0000;
    else if (msTick && ferrMs_ff != 16'hffff)
      ferrMs_ff <= ferrMs_ff + 16'h0001;
  end

  // Status word; reserved bits read zero
  always_ff @(posedge clk) begin
    if (!rst_b) statusWord <= 16'h0000;
    else begin
      statusWord <= 16'h0000;
      if (mode_ff == csm_pkg::ST_CSV || mode_ff == csm_pkg::ST_CST) begin
        statusWord[csm_pkg::STAT_SYNC_BIT] <= fieldbusSync;
        statusWord[csm_pkg::STAT_FOLLOW_BIT] <= fieldbusSync
                                                && targetValid;
      end
      if (mode_ff == csm_pkg::ST_STEP)
        statusWord[csm_pkg::STAT_FERR_BIT] <= closedLoop &&
          (ferrMs_ff > ferrTimeoutMs);
    end
  end

  // Rate limits and direction setup time are kept by the pulse source
  // assumed; edge detector needs highs and lows of 1+ cycles

  property p_follow;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_CSV && fieldbusSync && targetValid)
      |=> statusWord[csm_pkg::STAT_FOLLOW_BIT];
  endproperty
  a_follow: assert property (p_follow)
    else $error("follow bit low");

  property p_sync;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_CST) |=>
      statusWord[csm_pkg::STAT_SYNC_BIT] == $past(fieldbusSync);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync bit wrong");

  property p_mode_step;
    @(posedge clk) disable iff (!rst_b)
      (modeSel == csm_pkg::MODE_STEPDIR) |=> mode_ff == csm_pkg::ST_STEP;
  endproperty
  a_mode_step: assert property (p_mode_step)
    else $error("no step mode");

  property p_pins;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_STEP) |=> pinAltMask == 2'b11;
  endproperty
  a_pins: assert property (p_pins)
    else $error("pins not forced");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      !cycleTick |=> $stable(demandPos);
  endproperty
  a_hold: assert property (p_hold)
    else $error("demand moved off cycle");

  property p_vel;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_CSV && targetValid) |=>
      velDemand == $past(setpt.targetVel) + $past(setpt.velOffset);
  endproperty
  a_vel: assert property (p_vel)
    else $error("velocity sum wrong");

  property p_tidx;
    @(posedge clk) disable iff (!rst_b)
      (timeIndex != csm_pkg::TIME_INDEX_MS) |=> !cycleTick;
  endproperty
  a_tidx: assert property (p_tidx)
    else $error("tick on bad index");

  property p_trq;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_CST) |=>
      ($signed(32'(torqueDemand)) <= $signed({16'h0000,
        umin($past(setpt.maxTorque), $past(setpt.maxCurrent))}));
  endproperty
  a_trq: assert property (p_trq)
    else $error("torque over limit");

  // Following error flag follows the timer once it passes the limit
  property p_ferr;
    @(posedge clk) disable iff (!rst_b)
      (mode_ff == csm_pkg::ST_STEP && closedLoop &&
       ferrMs_ff > ferrTimeoutMs) |=> statusWord[csm_pkg::STAT_FERR_BIT];
  endproperty
  a_ferr: assert property (p_ferr)
    else $error("following error bit low");

  property p_mode_csv;
    @(posedge clk) disable iff (!rst_b)
      (modeSel == csm_pkg::MODE_CSV) |=> mode_ff == csm_pkg::ST_CSV;
  endproperty
  a_mode_csv: assert property (p_mode_csv)
    else $error("no velocity mode");

  property p_mode_cst;
    @(posedge clk) disable iff (!rst_b)
      (modeSel == csm_pkg::MODE_CST) |=> mode_ff == csm_pkg::ST_CST;
  endproperty
  a_mode_cst: assert property (p_mode_cst)
    else $error("no torque mode");

endmodule

// >>> tb/pulse_source.sv
// Purpose: Behavioural pulse source driving the step/direction pins
// Assumes: 100 ns clock; pins idle low as with a pull-down
// Notes:   Timing is kept at the slowest legal spacing only
`timescale 1ns/1ns
module pulse_source (
  // Clock
  input  wire logic clk,
  // Pins toward the block
  output logic      stepPin,
  output logic      dirPin,
  output logic      counterclockwisePin
);
  logic lastDir;

  // Idle pin levels at start
  initial begin
    stepPin = 1'b0;
    dirPin  = 1'b0;
    counterclockwisePin = 1'b0;
    lastDir = 1'b0;
  end

  // Sends n pulses; sub picks clock+dir or the split pins
  task automatic send(input int n, input logic dir, input logic sub);
    if (sub == 1'b0 && dir != lastDir) begin
      @(posedge clk);
      dirPin  <= dir;
      lastDir = dir;
      repeat (350) @(posedge clk); // Settle after a turn
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (sub && dir)
        counterclockwisePin <= 1'b1;
      else
        stepPin <= 1'b1;
      repeat (2) @(posedge clk); // High 200 ns, period 1 us
      stepPin <= 1'b0;
      counterclockwisePin <= 1'b0;
      repeat (7) @(posedge clk);
    end
  endtask
endmodule

// >>> tb/test_cyclic_step_modes.sv
// Purpose: Self-checking bench for the cyclic and step/direction front end
// Assumes: One cycle is 1 ms, so step checks wait on cycleTick
// Notes:   Pulses are sent just after a tick so none straddle a cycle
`timescale 1ns/1ns
module test_cyclic_step_modes;
  logic               clk, rst_b, fieldbusSync, targetValid, pulseSubtype;
  logic               stepPin, dirPin, counterclockwisePin;
  logic               closedLoop, cycleTick;
  logic               timeIndexErr;
  logic [7:0]         modeSel, timeIndex, polePairs;
  logic [15:0]        interpPeriod, controlWord, stepNum, stepDen;
  logic [15:0]        ferrTimeoutMs, statusWord, stepsPerRev;
  logic [1:0]         userAltMask, pinAltMask;
  logic signed [31:0] actualPos, velDemand, demandPos;
  logic [31:0]        ferrWindow;
  logic signed [15:0] torqueDemand;
  csm_pkg::setpt_s    sp;
  int                 n_errors, check_count, cycles;

  cyclic_step_modes cyclic_step_modes_inst (
    .clk(clk), .rst_b(rst_b), .modeSel(modeSel),
    .interpPeriod(interpPeriod), .timeIndex(timeIndex),
    .fieldbusSync(fieldbusSync), .targetValid(targetValid),
    .controlWord(controlWord), .setpt(sp), .pulseSubtype(pulseSubtype),
    .clockwisePulseInput(stepPin), .directionInput(dirPin),
    .counterclockwisePulseInput(counterclockwisePin), .stepNum(stepNum),
    .stepDen(stepDen), .polePairs(polePairs), .closedLoop(closedLoop),
    .actualPos(actualPos), .ferrWindow(ferrWindow),
    .ferrTimeoutMs(ferrTimeoutMs), .userAltMask(userAltMask),
    .statusWord(statusWord), .velDemand(velDemand),
    .torqueDemand(torqueDemand), .demandPos(demandPos),
    .cycleTick(cycleTick), .pinAltMask(pinAltMask),
    .stepsPerRev(stepsPerRev), .timeIndexErr(timeIndexErr));

  pulse_source pulse_source_inst (
    .clk(clk), .stepPin(stepPin), .dirPin(dirPin),
    .counterclockwisePin(counterclockwisePin));

  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Hang guard, above the expected run of about 91k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Waits for a tick, then lets demandPos land
  task automatic waitTick();
    int k;
    k = 0;
    while (cycleTick !== 1'b1 && k < 12000) begin
      @(negedge clk);
      k++;
    end
    chk("tick", 32'(k < 12000), 32'h1);
    repeat (2) @(negedge clk);
  endtask

  // Clock plus direction pulses, both senses
  task automatic stepClockDir();
    @(posedge clk);
    modeSel <= csm_pkg::MODE_STEPDIR;
    waitTick();
    pulse_source_inst.send(3, 1'b0, csm_pkg::SUB_CLK_DIR);
    waitTick();
    chk("posFwd", demandPos, 32'sd384);
    pulse_source_inst.send(1, 1'b1, csm_pkg::SUB_CLK_DIR);
    waitTick();
    chk("posRev", demandPos, 32'sd256);
    chk("pins", 32'(pinAltMask), 32'h3);
    chk("steps", 32'(stepsPerRev), 32'd12);
  endtask

  // Split-pin pulses with a stale direction pin, then following error
  task automatic stepSplitPins();
    @(posedge clk);
    pulseSubtype <= csm_pkg::SUB_SPLIT_PINS;
    stepNum      <= csm_pkg::FULL_STEP;
    stepDen      <= 16'h0002;
    waitTick();
    pulse_source_inst.send(1, 1'b0, csm_pkg::SUB_SPLIT_PINS);
    pulse_source_inst.send(3, 1'b1, csm_pkg::SUB_SPLIT_PINS);
    waitTick();
    chk("posSplit", demandPos, -32'sd256);
    chk("ferrOff", 32'(statusWord), 32'h0);
    @(posedge clk);
    closedLoop    <= 1'b1;
    ferrWindow    <= 32'd10;
    ferrTimeoutMs <= 16'h0001;
    repeat (3) waitTick();
    chk("ferr", 32'(statusWord), 32'h2000);
  endtask

  // Unsupported time index stops the cycle
  task automatic badIndex();
    int seen;
    seen = 0;
    @(posedge clk);
    timeIndex <= 8'h00;
    repeat (5) @(negedge clk);
    chk("tiErr", 32'(timeIndexErr), 32'h1);
    repeat (11000) begin
      @(negedge clk);
      if (cycleTick === 1'b1)
        seen++;
    end
    chk("noTick", seen, 0);
    @(posedge clk);
    timeIndex <= csm_pkg::TIME_INDEX_MS;
    repeat (3) @(negedge clk);
    chk("tiOk", 32'(timeIndexErr), 32'h0);
  endtask

  // Velocity with offset and the sync/follow bits
  task automatic cyclicVel();
    @(posedge clk);
    modeSel      <= csm_pkg::MODE_CSV;
    closedLoop   <= 1'b0;
    controlWord  <= 16'hffff;
    fieldbusSync <= 1'b1;
    targetValid  <= 1'b1;
    sp.targetVel <= 32'sd100;
    sp.velOffset <= -32'sd5;
    repeat (4) @(negedge clk);
    chk("vel", velDemand, 32'sd95);
    chk("stat", 32'(statusWord), 32'h1100);
    chk("pinsUser", 32'(pinAltMask), 32'h1);
    @(posedge clk);
    targetValid <= 1'b0;
    repeat (3) @(negedge clk);
    chk("statIgn", 32'(statusWord), 32'h0100);
    @(posedge clk);
    fieldbusSync <= 1'b0;
    repeat (3) @(negedge clk);
    chk("statOff", 32'(statusWord), 32'h0000);
  endtask

  // Torque clamp at the lesser limit, offset in per-mille
  task automatic cyclicTorque();
    logic signed [15:0] tgt [3] = '{16'sd1000, -16'sd1000, 16'sd100};
    logic signed [15:0] ofs [3] = '{16'sd0, 16'sd0, 16'sd20};
    logic signed [15:0] exq [3] = '{16'sd300, -16'sd300, 16'sd120};
    @(posedge clk);
    modeSel       <= csm_pkg::MODE_CST;
    targetValid   <= 1'b1;
    sp.maxTorque  <= 16'd500;
    sp.maxCurrent <= 16'd300;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      sp.targetTorque <= tgt[i];
      sp.torqueOffset <= ofs[i];
      repeat (3) @(negedge clk);
      chk("torque", 32'(torqueDemand), 32'(exq[i]));
    end
    chk("velZero", velDemand, 32'h0);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_b, fieldbusSync, targetValid, pulseSubtype, closedLoop} = '0;
    {modeSel, controlWord, ferrTimeoutMs, ferrWindow, actualPos} = '0;
    {n_errors, check_count, cycles} = '0;
    sp           = '0;
    timeIndex    = csm_pkg::TIME_INDEX_MS;
    interpPeriod = csm_pkg::PERIOD_RST;
    stepNum      = csm_pkg::STEP_NUM_RST;
    stepDen      = csm_pkg::STEP_DEN_RST;
    polePairs    = 8'h03;
    userAltMask  = 2'b01;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("rstPos", demandPos, 32'h0);
    chk("rstStat", 32'(statusWord), 32'h0);
    stepClockDir();
    stepSplitPins();
    badIndex();
    cyclicVel();
    cyclicTorque();
    print_verdict();
  end
endmodule
